// file: inc/acs_defs.svh
// timing and reset constants of the autobaud serial converter
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// core clock rate in Hz
`define ACS_CLK_HZ 100000000
// slowest and fastest line rates in bits per second
`define ACS_BAUD_MIN 1200
`define ACS_BAUD_MAX 115200
// longest bit in core cycles, rounded down
`define ACS_BIT_CYC_MAX (`ACS_CLK_HZ / `ACS_BAUD_MIN)
// shortest bit in core cycles
`define ACS_BIT_CYC_MIN (`ACS_CLK_HZ / `ACS_BAUD_MAX)
// low pulses shorter than this are noise, not bits
`define ACS_GLITCH_CYC (`ACS_BIT_CYC_MIN / 2)
// bit times of quiet line before the driver is released
`define ACS_HOLD_BITS 12
// idle line level (mark)
`define ACS_LINE_IDLE 1'h1

`endif

// file: inc/acs_pkg.sv
// types and shared arithmetic of the autobaud serial converter
package acs_pkg;

  // ********************************
  // line direction
  // ********************************
  typedef enum logic {ACS_LISTEN, ACS_DRIVE} acs_dir_e;

  // ********************************
  // counters
  // ********************************
  typedef logic [16:0] acs_bit_t;
  typedef logic [20:0] acs_cnt_t;

  // saturating increment, so long quiet lines never wrap
  function automatic acs_cnt_t acs_inc_sat(input acs_cnt_t v);
    acs_cnt_t r;
    r = (v == 21'h1FFFFF) ? v : v + 21'h000001;
    return r;
  endfunction

endpackage

// file: rtl/acs_bit_timer.sv
// measures the shortest low pulse of a host burst as the bit time
`timescale 1ns/100ps
`include "acs_defs.svh"
module acs_bit_timer
  import acs_pkg::*;
#(
  parameter acs_bit_t BIT_CYC_MAX = 17'(`ACS_BIT_CYC_MAX)
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // sampled line and burst start
  input wire logic line,
  input wire logic restart,
  // measured bit time in core cycles
  output acs_bit_t bit_cyc
);

  // ********************************
  // edge detection and run length
  // ********************************
  logic line_q_reg;
  acs_bit_t run_reg;
  acs_bit_t run_next;
  acs_bit_t bit_reg;
  acs_bit_t bit_next;
  acs_cnt_t run_inc;
  wire logic fall = line_q_reg & ~line;
  wire logic rise = ~line_q_reg & line;
  wire logic run_valid = rise && (run_reg >= 17'(`ACS_GLITCH_CYC));

  assign run_inc = acs_inc_sat({4'h0, run_reg});
  assign run_next = fall ? 17'h00001 : (~line ? run_inc[16:0] : run_reg);
  // a burst starts from the slowest rate; every clean low run can
  // only shorten the estimate; a run of several equal bits is harmless up to 131071 cycles, where run_reg wraps
  assign bit_next = restart ? BIT_CYC_MAX :
                    (run_valid && run_reg < bit_reg) ? run_reg : bit_reg;
  assign bit_cyc = bit_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      line_q_reg <= `ACS_LINE_IDLE;
      run_reg <= 17'h00000;
      bit_reg <= BIT_CYC_MAX;
    end
    else
    begin
      line_q_reg <= line;
      run_reg <= run_next;
      bit_reg <= bit_next;
    end
  end

endmodule

// file: rtl/acs_converter.sv
// host serial to half-duplex network converter with automatic direction
`timescale 1ns/100ps
`include "acs_defs.svh"

// What the system requires
// R01: follows any rate from 1200 to 115200; low runs over 131071 cycles wrap the 17-bit run counter
// R02: ten-bit network frames pass whole
// R03: frames pass bit for bit, never reframed
// R04: one party drives the shared pair
// R05: drives network only while host sends
// R06: host to network, network to host
// R07: host sends at target module rate
// R08: modules match address, others discard
// R09: modules ignore commands at other rates
// R10: addressed module answers over network
// R11: optional two checksum bytes, switchable
// R12: release driver after last stop bit
module acs_converter
  import acs_pkg::*;
#(
  parameter acs_bit_t BIT_CYC_MAX = 17'(`ACS_BIT_CYC_MAX)
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // host serial port
  input wire logic host_rxd,
  output logic host_txd,
  // network transceiver
  input wire logic net_rxd,
  output logic net_txd,
  output logic net_de,
  output logic net_re_n,
  // status
  output acs_bit_t bit_cyc
);

  // ********************************
  // state
  // ********************************
  acs_dir_e state_reg;
  acs_dir_e state_next;
  acs_cnt_t idle_reg;
  acs_cnt_t idle_next;
  acs_cnt_t hold_cyc;
  logic host_txd_reg;
  logic host_txd_next;
  logic net_txd_reg;
  logic net_txd_next;
  acs_bit_t bit_cyc_w;

  // ********************************
  // rate tracking
  // ********************************
  wire logic burst_start = (state_reg == ACS_LISTEN) && !host_rxd;

  // the rate is re-learnt from every burst, so each command may use
  // its own rate with no setting by software
  acs_bit_timer #(
    .BIT_CYC_MAX(BIT_CYC_MAX)
  ) u_bit_timer (
    .core_clk(core_clk),
    .reset(reset),
    .line(host_rxd),
    .restart(burst_start), // R01
    .bit_cyc(bit_cyc_w)
  );

  // hold covers an eleven-bit frame ending in a run of ones
  assign hold_cyc = {4'h0, bit_cyc_w} * 21'(`ACS_HOLD_BITS); // R02 R12
  wire logic hold_done = host_rxd && (idle_reg >= hold_cyc);

  // ********************************
  // direction control
  // ********************************
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ACS_LISTEN:
      begin
        if (!host_rxd)
          state_next = ACS_DRIVE; // R05
      end
      ACS_DRIVE:
      begin
        if (hold_done)
          state_next = ACS_LISTEN; // R12
      end
      default:
        state_next = ACS_LISTEN;
    endcase
  end

  // quiet-line counter, restarted by every low host bit
  assign idle_next = (state_reg == ACS_LISTEN || !host_rxd) ?
                     21'h000000 : acs_inc_sat(idle_reg); // R12

  // ********************************
  // data path
  // ********************************
  // bits are copied, not decoded, so any parity or stop count survives
  assign net_txd_next = (state_next == ACS_DRIVE) ?
                        host_rxd : `ACS_LINE_IDLE; // R03 R06
  // own transmission is not echoed back; the host sees mark meanwhile
  assign host_txd_next = (state_next == ACS_DRIVE) ?
                         `ACS_LINE_IDLE : net_rxd; // R04 R06

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg <= ACS_LISTEN;
      idle_reg <= 21'h000000;
      net_txd_reg <= `ACS_LINE_IDLE;
      host_txd_reg <= `ACS_LINE_IDLE;
    end
    else
    begin
      state_reg <= state_next;
      idle_reg <= idle_next;
      net_txd_reg <= net_txd_next;
      host_txd_reg <= host_txd_next;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign net_txd = net_txd_reg;
  assign net_de = (state_reg == ACS_DRIVE); // R04 R05
  assign net_re_n = (state_reg == ACS_DRIVE); // R04
  assign host_txd = host_txd_reg;
  assign bit_cyc = bit_cyc_w;

  // ********************************
  // checks
  // ********************************
  sequence seq_host_low2;
    !host_rxd ##1 !host_rxd;
  endsequence

  sequence seq_burst_begin;
    (state_reg == ACS_LISTEN) && !host_rxd;
  endsequence

  chk_drive_on_start: assert property ( // R05
    @(posedge core_clk) disable iff (reset)
    seq_burst_begin |=> net_de && !net_txd)
    else $error("driver not enabled at host start bit");

  chk_tx_copy: assert property ( // R06
    @(posedge core_clk) disable iff (reset)
    (state_reg == ACS_DRIVE) ##1 (state_reg == ACS_DRIVE)
    |-> net_txd == $past(host_rxd))
    else $error("network data differs from host data");

  chk_rx_copy: assert property ( // R06
    @(posedge core_clk) disable iff (reset)
    (state_reg == ACS_LISTEN) && host_rxd
    |=> host_txd == $past(net_rxd))
    else $error("host data differs from network data");

  chk_rx_muted: assert property ( // R04
    @(posedge core_clk) disable iff (reset)
    net_de |-> host_txd && net_re_n)
    else $error("receiver open while driving");

  chk_release_idle: assert property ( // R12
    @(posedge core_clk) disable iff (reset)
    net_de && host_rxd && (idle_reg >= hold_cyc)
    |=> !net_de && net_txd)
    else $error("driver not released after quiet line");

  chk_hold_frame: assert property ( // R02
    @(posedge core_clk) disable iff (reset)
    net_de && (idle_reg < hold_cyc) |=> net_de)
    else $error("driver dropped inside a frame");

  chk_low_passes: assert property ( // R03
    @(posedge core_clk) disable iff (reset)
    (state_reg == ACS_DRIVE) ##0 seq_host_low2 |-> !net_txd ##1 !net_txd)
    else $error("low bits not passed through");

  chk_rate_range: assert property ( // R01
    @(posedge core_clk) disable iff (reset)
    (bit_cyc_w >= 17'(`ACS_GLITCH_CYC)) && (bit_cyc_w <= BIT_CYC_MAX))
    else $error("bit time outside supported rates");

  chk_rate_reset: assert property ( // R01
    @(posedge core_clk) disable iff (reset)
    seq_burst_begin |=> bit_cyc_w == BIT_CYC_MAX)
    else $error("rate not relearnt at burst start");

endmodule

// file: tb/acs_net_model.sv
// addressed network module that answers the converter over the pair
`timescale 1ns/100ps
`include "acs_defs.svh"
module acs_net_model
#(
  // own address is arbitrary; own rate is the fastest line rate
  parameter logic [7:0] ADDR = 8'h35,
  parameter int BIT = `ACS_BIT_CYC_MIN
)
(
  // clock
  input wire logic core_clk,
  // converter transceiver side
  input wire logic net_de,
  input wire logic net_txd,
  output logic net_rxd
);
  // bias resistors hold an undriven pair at mark
  initial net_rxd = 1'h1;

  // ********************************
  // command listener
  // ********************************
  logic [7:0] heard;
  logic heard_ok;
  // a released pair rests at mark
  wire logic pair = net_de ? net_txd : 1'h1;

  initial
  begin
    int run;
    heard = 8'h00;
    heard_ok = 1'h0;
    forever
    begin
      @(negedge pair);
      heard_ok = 1'h0;
      run = 0;
      while (pair === 1'h0)
      begin
        @(negedge core_clk);
        run++;
      end
      // a start bit of another length belongs to another rate
      if (run > BIT - BIT / 4 && run < BIT + BIT / 4)
      begin
        repeat (BIT / 2) @(negedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
          heard[i] = pair;
          repeat (BIT) @(negedge core_clk);
        end
        heard_ok = 1'h1;
      end
    end
  end

  // ********************************
  // response transmitter
  // ********************************
  task automatic send(input logic [11:0] f, input int n, input int b);
    @(posedge core_clk);
    // never talk over the converter's driver
    while (net_de !== 1'h0)
      @(posedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      net_rxd <= f[i];
      repeat (b) @(posedge core_clk);
    end
    net_rxd <= 1'h1;
  endtask

  // only the module whose address was heard at its own rate answers
  task automatic reply(input logic [11:0] f, input int n, input int b);
    if (heard_ok && heard == ADDR)
      send(f, n, b);
  endtask
endmodule

// file: tb/tb_acs_converter.sv
// self-checking bench of the autobaud serial converter
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("unexpected at %0t: got %h exp %h", $time, \
  g, e); end end
module tb_acs_converter;
  import acs_pkg::*;
  // short ceiling keeps the bench fast
  localparam acs_bit_t CMAX = 17'h007D0;
  // arbitrary address of the model; bit 0 set keeps the start bit alone
  localparam logic [7:0] NET_ADDR = 8'h35;
  logic core_clk, reset, host_rxd, host_txd, net_rxd, net_txd;
  logic net_de, net_re_n;
  acs_bit_t bit_cyc;
  int err_total = 0;
  int samples_checked = 0;

  acs_converter #(.BIT_CYC_MAX(CMAX)) i_acs_converter (
    .core_clk(core_clk), .reset(reset), .host_rxd(host_rxd),
    .host_txd(host_txd), .net_rxd(net_rxd), .net_txd(net_txd),
    .net_de(net_de), .net_re_n(net_re_n), .bit_cyc(bit_cyc));
  acs_net_model #(.ADDR(NET_ADDR)) i_acs_net_model (
    .core_clk(core_clk), .net_de(net_de), .net_txd(net_txd),
    .net_rxd(net_rxd));

  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ********************************
  // helpers
  // ********************************
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // start bit, data lsb first, even parity for the 11-bit form, stops
  function automatic logic [11:0] frame(input logic [7:0] d, input bit w);
    if (w)
      return {3'h7, ^d[6:0], d[6:0], 1'h0};
    return {3'h7, d, 1'h0};
  endfunction

  // response string: data character, then with the checksum on two
  // hex characters of its byte sum
  function automatic logic [7:0] resp_char(input logic [7:0] d, input int c);
    logic [3:0] v;
    if (c == 0)
      return d;
    v = (c == 1) ? d[7:4] : d[3:0];
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction

  task automatic host_send(input logic [11:0] f, input int n, input int b);
    int rise;
    rise = 0;
    // quiet time counts from the last rising edge, not the stop bit
    for (int i = 0; i < n; i++)
      if (!f[i])
        rise = (i + 1) * b;
    for (int k = 0; k < rise + 12 * b + 4; k++)
    begin
      @(posedge core_clk);
      host_rxd <= (k < n * b) ? f[k / b] : 1'h1;
      @(negedge core_clk);
      if (k < n * b && k % b == b / 2)
      begin
        `CHK(net_txd, f[k / b])
        `CHK({net_de, net_re_n, host_txd}, 3'h7)
      end
      if (k == rise + 12 * b - 4)
        `CHK(net_de, 1'h1)
    end
    `CHK({net_de, net_re_n, net_txd}, 3'h1)
    `CHK(bit_cyc, 17'(b))
  endtask

  task automatic net_recv(input logic [11:0] f, input int n, input int b,
                          input bit ans);
    fork
      i_acs_net_model.reply(f, n, b);
      begin
        // an ignored command leaves the host line at mark
        if (ans)
          @(negedge net_rxd);
        repeat (b / 2) @(negedge core_clk);
        for (int i = 0; i < n; i++)
        begin
          `CHK({host_txd, net_de}, {(ans ? f[i] : 1'h1), 1'h0})
          repeat (b) @(negedge core_clk);
        end
      end
    join
  endtask

  // ********************************
  // sequence
  // ********************************
  initial
  begin
    repeat (96000) @(posedge core_clk);
    err_total++;
    wrap_up();
  end

  initial
  begin
    logic [7:0] d;
    host_rxd = 1'h1;
    reset = 1'h1;
    void'($urandom(11));
    repeat (10) @(posedge core_clk);
    reset <= 1'h0;
    @(negedge core_clk);
    `CHK({host_txd, net_txd, net_de, net_re_n}, 4'hC)
    `CHK(bit_cyc, CMAX)
    // pass 0: 10-bit at 115200 to the model, answered with checksum on;
    // pass 1: 11-bit at 57600, ignored by the model for its rate
    for (int t = 0; t < 2; t++)
    begin
      // isolated start bit gives an exact bit-time measurement
      d = t[0] ? (8'($urandom) | 8'h01) : NET_ADDR;
      host_send(frame(d, t[0]), 10 + t, 868 * (t + 1));
      d = 8'($urandom);
      for (int c = 0; c < 3 - 2 * t; c++)
        net_recv(frame(resp_char(d, c), t[0]), 10 + t, 868, !t[0]);
    end
    wrap_up();
  end
endmodule
